// >>> dv/bah_far_side.sv
`timescale 1ns/1ps
module bah_far_side (
	input  wire       aclk,
	input  wire       strobe_n,
	input  wire       wide,
	input  wire [2:0] delay,
	output reg        ack_low_n,
	output reg        ack_high_n
);
	reg [2:0] cnt = 3'h0;
	initial ack_low_n = 1'b1;
	initial ack_high_n = 1'b1;
	// a memory slave that answers after a chosen wait, released when idle
	always @(posedge aclk) begin
		if (strobe_n) begin
			cnt <= 3'h0;
			ack_low_n <= 1'b1;
			ack_high_n <= 1'b1;
		end else if (cnt == delay) begin
			ack_high_n <= 1'b0;
			ack_low_n <= !wide;
		end else
			cnt <= cnt + 3'h1;
	end
endmodule // bah_far_side

// >>> dv/bah_handshake_bench.sv
`timescale 1ns/1ps
`include "bah_consts.vh"
module bah_handshake_bench;
	logic aclk = 0, aresetn = 0, bus_mode_select = 1, hold_acknowledge = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, data_out, d, w;
	logic [3:0] s_axi_wstrb = 0, ext_n = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, data_oe_n, fs_lo, fs_hi;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, b, strap = 0, exp_u = 0;
	logic hard_reset_n = 0, grant_input_n = 1, slave_select_n = 1;
	logic slave_direction = 1, wide = 0;
	logic [2:0] dly = 0;
	logic [15:0] data_in = 0;
	logic address_strobe_n_in, address_strobe_n_out, address_strobe_n_oe_n;
	logic grant_acknowledge_n_in, grant_acknowledge_n_out;
	logic grant_acknowledge_n_oe_n, size_ack_low_n_in, size_ack_low_n_out;
	logic size_ack_low_n_oe_n, size_ack_high_n_in, size_ack_high_n_out;
	logic size_ack_high_n_oe_n, user_pin_zero_in, user_pin_zero_out;
	logic user_pin_zero_oe_n, user_pin_one_in, user_pin_one_out;
	logic user_pin_one_oe_n;
	logic [31:0] seed = 32'h0001_47fc;
	int fail_count = 0, comparisons = 0, cyc = 0, i;
	// pulled-up lines; ext_n stands for another master or slave holding one
	assign address_strobe_n_in = (address_strobe_n_oe_n | address_strobe_n_out)
		& ext_n[0];
	assign grant_acknowledge_n_in = (grant_acknowledge_n_oe_n |
		grant_acknowledge_n_out) & ext_n[1];
	assign size_ack_low_n_in = (size_ack_low_n_oe_n | size_ack_low_n_out)
		& fs_lo & ext_n[2];
	assign size_ack_high_n_in = (size_ack_high_n_oe_n | size_ack_high_n_out)
		& fs_hi & ext_n[3];
	assign user_pin_zero_in = user_pin_zero_oe_n ? strap[0] : user_pin_zero_out;
	assign user_pin_one_in = user_pin_one_oe_n ? strap[1] : user_pin_one_out;
	initial forever #20 aclk = ~aclk;
	bah_far_side bah_far_side_i (.aclk, .strobe_n(address_strobe_n_in),
		.wide, .delay(dly), .ack_low_n(fs_lo), .ack_high_n(fs_hi));
	bah_handshake bah_handshake_i (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.bus_mode_select, .hard_reset_n, .hold_acknowledge, .grant_input_n,
		.slave_select_n, .slave_direction, .address_strobe_n_in,
		.address_strobe_n_out, .address_strobe_n_oe_n, .grant_acknowledge_n_in,
		.grant_acknowledge_n_out, .grant_acknowledge_n_oe_n,
		.size_ack_low_n_in, .size_ack_low_n_out, .size_ack_low_n_oe_n,
		.size_ack_high_n_in, .size_ack_high_n_out, .size_ack_high_n_oe_n,
		.data_in, .data_out, .data_oe_n, .user_pin_zero_in, .user_pin_zero_out,
		.user_pin_zero_oe_n, .user_pin_one_in, .user_pin_one_out,
		.user_pin_one_oe_n);
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic [31:0] cfg_exp(input [31:0] v, input [1:0] u);
		cfg_exp = (v & `BAH_CFG_WMASK) | {22'h0, u, 8'h00};
	endfunction
	task test_done;
		if (fail_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task wr(input [4:0] a, input [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while ((s_axi_awvalid && !s_axi_awready) ||
			(s_axi_wvalid && !s_axi_wready));
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		b = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask
	task rd(input [4:0] a, output [31:0] v, output [1:0] rs);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			test_done;
		end
	end
	always @(negedge aclk) if (!grant_acknowledge_n_oe_n &&
		!grant_acknowledge_n_out && !user_pin_zero_oe_n)
		chk({user_pin_one_out, user_pin_zero_out}, exp_u);
	initial begin
		seed = lfsr(seed);
		strap <= seed[1:0];
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
		hard_reset_n <= 1;
		repeat (4) @(posedge aclk);
		strap <= ~strap;
		rd(`BAH_OFS_CONFIG, d, r);
		chk(d, cfg_exp(`BAH_CFG_RESET, ~strap));
		rd(5'h14, d, r);
		chk(r, `BAH_RESP_SLVERR);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			w = (seed & ~32'h0000_0420) | {21'h0, i[1], 4'h0, i[0], 5'h00};
			wr(`BAH_OFS_CONFIG, w);
			chk(b, `BAH_RESP_OKAY);
			exp_u <= w[12:11];
			rd(`BAH_OFS_CONFIG, d, r);
			chk(d, cfg_exp(w, ~strap));
			dly <= seed[15:13];
			wide <= 0;
			ext_n <= 4'hf ^ (4'h1 << i);
			wr(`BAH_OFS_CONTROL, 32'h1);
			repeat (12) @(posedge aclk);
			chk(grant_acknowledge_n_oe_n, 1);
			grant_input_n <= 0;
			repeat (12) @(posedge aclk);
			chk(grant_acknowledge_n_oe_n, 1);
			ext_n <= 4'hf;
			if (i[0]) begin
				// wide port given only the high ack must keep waiting
				repeat (30) @(posedge aclk);
				rd(`BAH_OFS_STATUS, d, r);
				chk(d[0], 0);
				wide <= 1;
			end
			do rd(`BAH_OFS_STATUS, d, r); while (d[0] !== 1'b1);
			grant_input_n <= 1;
			wr(`BAH_OFS_STATUS, 32'h1);
		end
		hold_acknowledge <= 1;
		repeat (3) @(posedge aclk);
		chk({user_pin_one_oe_n, user_pin_zero_oe_n}, 0);
		hold_acknowledge <= 0;
		repeat (3) @(posedge aclk);
		chk({user_pin_one_oe_n, user_pin_zero_oe_n}, 3);
		seed = lfsr(seed);
		wr(`BAH_OFS_SLAVE_RD, seed);
		slave_select_n <= 0;
		while (size_ack_low_n_oe_n !== 1'b0) @(posedge aclk);
		chk({data_oe_n, data_out[15:0]}, {1'b0, seed[15:0]});
		slave_select_n <= 1;
		repeat (6) @(posedge aclk);
		data_in <= seed[31:16];
		slave_direction <= 0;
		slave_select_n <= 0;
		while (size_ack_low_n_oe_n !== 1'b0) @(posedge aclk);
		slave_select_n <= 1;
		repeat (6) @(posedge aclk);
		wr(`BAH_OFS_SLAVE_WR, ~seed);
		chk(b, `BAH_RESP_SLVERR);
		rd(`BAH_OFS_SLAVE_WR, d, r);
		chk(d, {16'h0000, seed[31:16]});
		bus_mode_select <= 0;
		slave_select_n <= 0;
		repeat (12) @(posedge aclk);
		chk(size_ack_low_n_oe_n, 1);
		test_done;
	end
endmodule // bah_handshake_bench

// >>> dv/bah_handshake_monitor.sv
`timescale 1ns/1ps
module bah_handshake_monitor (
	input wire        aclk,
	input wire        aresetn,
	input wire        bus_mode_select,
	input wire        hold_acknowledge,
	input wire        grant_input_n,
	input wire        address_strobe_n_in,
	input wire        address_strobe_n_out,
	input wire        address_strobe_n_oe_n,
	input wire        grant_acknowledge_n_in,
	input wire        grant_acknowledge_n_out,
	input wire        grant_acknowledge_n_oe_n,
	input wire        size_ack_low_n_in,
	input wire        size_ack_low_n_out,
	input wire        size_ack_low_n_oe_n,
	input wire        size_ack_high_n_in,
	input wire        size_ack_high_n_out,
	input wire        size_ack_high_n_oe_n,
	input wire [31:0] data_out,
	input wire        data_oe_n,
	input wire        user_pin_zero_oe_n,
	input wire        user_pin_one_oe_n
);
	wire gack_on = !grant_acknowledge_n_oe_n && !grant_acknowledge_n_out;
	wire strb_on = !address_strobe_n_oe_n && !address_strobe_n_out;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// two synchroniser flops plus the registered pin: depth of three
	a_gack_prereq: assert property ($rose(gack_on) |->
		!$past(grant_input_n, 3) && $past(address_strobe_n_in, 3) &&
		$past(grant_acknowledge_n_in, 3) && $past(size_ack_low_n_in, 3) &&
		$past(size_ack_high_n_in, 3)) else $error("grant ack too early");
	a_mode_gate: assert property (!bus_mode_select |->
		size_ack_low_n_oe_n && size_ack_high_n_oe_n)
		else $error("size ack driven outside mode one");
	a_slave_both: assert property (
		!size_ack_low_n_oe_n || !size_ack_high_n_oe_n |->
		!size_ack_low_n_oe_n && !size_ack_high_n_oe_n &&
		!size_ack_low_n_out && !size_ack_high_n_out)
		else $error("slave ack not both low");
	a_upper_lanes: assert property (
		!data_oe_n |-> data_out[31:16] == 16'h0000)
		else $error("upper data lanes not idle value");
	a_strobe_wait: assert property (
		strb_on && size_ack_high_n_in && $past(size_ack_high_n_in) |=>
		!address_strobe_n_out) else $error("cycle ended without ack");
	a_strobe_owned: assert property (strb_on |-> gack_on)
		else $error("strobe without grant ack");
	a_user_master: assert property (
		gack_on && $past(gack_on) |->
		!user_pin_zero_oe_n && !user_pin_one_oe_n)
		else $error("user pins not driven as master");
	a_user_float: assert property (
		(!gack_on && !hold_acknowledge) [*3] |->
		user_pin_zero_oe_n && user_pin_one_oe_n)
		else $error("user pins driven while not master");
endmodule // bah_handshake_monitor

bind bah_handshake bah_handshake_monitor bah_handshake_monitor_i (
	.aclk, .aresetn, .bus_mode_select, .hold_acknowledge, .grant_input_n,
	.address_strobe_n_in, .address_strobe_n_out, .address_strobe_n_oe_n,
	.grant_acknowledge_n_in, .grant_acknowledge_n_out,
	.grant_acknowledge_n_oe_n, .size_ack_low_n_in, .size_ack_low_n_out,
	.size_ack_low_n_oe_n, .size_ack_high_n_in, .size_ack_high_n_out,
	.size_ack_high_n_oe_n, .data_out, .data_oe_n, .user_pin_zero_oe_n,
	.user_pin_one_oe_n);

// >>> inc/bah_consts.vh
`ifndef BAH_CONSTS_VH
`define BAH_CONSTS_VH

// register byte offsets
`define BAH_OFS_CONFIG      5'h00
`define BAH_OFS_CONTROL     5'h04
`define BAH_OFS_STATUS      5'h08
`define BAH_OFS_SLAVE_RD    5'h0c
`define BAH_OFS_SLAVE_WR    5'h10

// data_config_register fields
`define BAH_CFG_WIDTH32     5
`define BAH_CFG_USER_IN0    8
`define BAH_CFG_USER_IN1    9
`define BAH_CFG_SYNC        10
`define BAH_CFG_USER_OUT0   11
`define BAH_CFG_USER_OUT1   12
`define BAH_CFG_RESET       32'h0000_0020
`define BAH_CFG_WMASK       32'h0000_1c20

// control and status fields
`define BAH_CTL_START       0
`define BAH_STS_DONE        0
`define BAH_STS_STATE_LO    1
`define BAH_STS_OWN         4
`define BAH_STS_SLAVE       5

// bus responses
`define BAH_RESP_OKAY       2'b00
`define BAH_RESP_SLVERR     2'b10

// master cycle states
`define BAH_ST_IDLE         3'h0
`define BAH_ST_WAIT         3'h1
`define BAH_ST_OWN          3'h2
`define BAH_ST_STROBE       3'h3
`define BAH_ST_END          3'h4
`define BAH_ST_RELEASE      3'h5

// synchronised pin vector layout
`define BAH_SYN_W           24
`define BAH_SYN_GRANT       0
`define BAH_SYN_STROBE      1
`define BAH_SYN_GACK        2
`define BAH_SYN_SELECT      3
`define BAH_SYN_HRST        4
`define BAH_SYN_USER0       5
`define BAH_SYN_USER1       6
`define BAH_SYN_DIR         7
`define BAH_SYN_DATA_LO     8
`define BAH_SYN_RESET       24'h00_009f

`endif

// >>> verilog/bah_ack_sampler.v
`timescale 1ns/1ps
`include "bah_consts.vh"

module bah_ack_sampler (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       sync_mode,
	input  wire [1:0] ack_pin_n,
	output wire [1:0] ack_seen
);
	reg [1:0] stage1;
	reg [1:0] stage2;
	reg [1:0] stage3;

	always @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= 2'h3;
			stage2 <= 2'h3;
			stage3 <= 2'h3;
		end else begin
			stage1 <= ack_pin_n;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// asynchronous sampling needs two agreeing samples; costs one cycle
	assign ack_seen = sync_mode ? ~stage2 : (~stage2 & ~stage3);
endmodule // bah_ack_sampler

// >>> verilog/bah_handshake.v
`timescale 1ns/1ps
`include "bah_consts.vh"

module bah_handshake (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        bus_mode_select,
	input  wire        hard_reset_n,
	input  wire        hold_acknowledge,
	input  wire        grant_input_n,
	input  wire        slave_select_n,
	input  wire        slave_direction,
	input  wire        address_strobe_n_in,
	output reg         address_strobe_n_out,
	output reg         address_strobe_n_oe_n,
	input  wire        grant_acknowledge_n_in,
	output reg         grant_acknowledge_n_out,
	output reg         grant_acknowledge_n_oe_n,
	input  wire        size_ack_low_n_in,
	output wire        size_ack_low_n_out,
	output wire        size_ack_low_n_oe_n,
	input  wire        size_ack_high_n_in,
	output wire        size_ack_high_n_out,
	output wire        size_ack_high_n_oe_n,
	input  wire [15:0] data_in,
	output reg  [31:0] data_out,
	output wire        data_oe_n,
	input  wire        user_pin_zero_in,
	output reg         user_pin_zero_out,
	output reg         user_pin_zero_oe_n,
	input  wire        user_pin_one_in,
	output reg         user_pin_one_out,
	output reg         user_pin_one_oe_n
);
	wire [`BAH_SYN_W-1:0] pin_raw;
	reg  [`BAH_SYN_W-1:0] pin_meta;
	reg  [`BAH_SYN_W-1:0] pin_sync;
	wire [1:0]            ack_seen;
	reg  [31:0]           data_config_register;
	reg  [15:0]           slave_read_data;
	reg  [15:0]           slave_write_data;
	reg  [2:0]            state;
	reg  [2:0]            next_state;
	reg                   done_flag;
	reg                   start_req;
	reg                   slave_active;
	reg                   slave_ack;
	reg                   slave_read;
	reg                   aw_held;
	reg                   w_held;
	reg  [4:0]            aw_addr;
	reg  [31:0]           w_data;
	reg  [3:0]            w_strb;
	wire                  in_hard_reset;
	wire                  owns_bus;
	wire                  bus_free;
	wire                  ack_done;
	wire                  wr_fire;
	wire                  done_set;
	wire                  slave_hit;
	wire [31:0]           status_word;
	genvar                i;
	localparam [`BAH_SYN_W-1:0] syn_reset_val = `BAH_SYN_RESET;

	assign pin_raw = {data_in, slave_direction, user_pin_one_in,
		user_pin_zero_in, hard_reset_n, slave_select_n,
		grant_acknowledge_n_in, address_strobe_n_in, grant_input_n};

	// every pin except bus_mode_select and hold_acknowledge passes two flops before any logic looks at it
	generate
		for (i = 0; i < `BAH_SYN_W; i = i + 1) begin : g_sync
			always @(posedge aclk) begin
				if (!aresetn) begin
					pin_meta[i] <= syn_reset_val[i];
					pin_sync[i] <= syn_reset_val[i];
				end else begin
					pin_meta[i] <= pin_raw[i];
					pin_sync[i] <= pin_meta[i];
				end
			end
		end
	endgenerate

	bah_ack_sampler u_ack (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.sync_mode (data_config_register[`BAH_CFG_SYNC]),
		.ack_pin_n ({size_ack_high_n_in, size_ack_low_n_in}),
		.ack_seen  (ack_seen)
	);

	assign in_hard_reset = ~pin_sync[`BAH_SYN_HRST];
	assign owns_bus = (state == `BAH_ST_OWN) || (state == `BAH_ST_STROBE) ||
		(state == `BAH_ST_END);
	// previous master and slave must both have left the bus
	assign bus_free = ~pin_sync[`BAH_SYN_GRANT] &
		pin_sync[`BAH_SYN_STROBE] &
		~ack_seen[0] & ~ack_seen[1] & pin_sync[`BAH_SYN_GACK];
	// width comes from the config bit only, never from the ack pattern
	assign ack_done = data_config_register[`BAH_CFG_WIDTH32] ?
		(ack_seen[0] & ack_seen[1]) :
		ack_seen[1];

	always @* begin
		next_state = state;
		case (state)
		`BAH_ST_IDLE: begin
			if (start_req && bus_mode_select)
				next_state = `BAH_ST_WAIT;
		end
		`BAH_ST_WAIT: begin
			if (bus_free && !slave_active)
				next_state = `BAH_ST_OWN;
		end
		`BAH_ST_OWN: begin
			next_state = `BAH_ST_STROBE;
		end
		`BAH_ST_STROBE: begin
			if (ack_done)
				next_state = `BAH_ST_END;
		end
		`BAH_ST_END: begin
			next_state = `BAH_ST_RELEASE;
		end
		default: begin
			next_state = `BAH_ST_IDLE;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn || in_hard_reset)
			state <= `BAH_ST_IDLE;
		else
			state <= next_state;
	end

	// master pin drive; released pins are driven high one cycle first, except in hard reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			grant_acknowledge_n_out  <= 1'b1;
			grant_acknowledge_n_oe_n <= 1'b1;
			address_strobe_n_out     <= 1'b1;
			address_strobe_n_oe_n    <= 1'b1;
		end else begin
			grant_acknowledge_n_out  <= ~(next_state == `BAH_ST_OWN ||
				next_state == `BAH_ST_STROBE ||
				next_state == `BAH_ST_END);
			grant_acknowledge_n_oe_n <= (next_state == `BAH_ST_IDLE) ||
				(next_state == `BAH_ST_WAIT) || in_hard_reset;
			address_strobe_n_out     <= ~(next_state == `BAH_ST_STROBE);
			address_strobe_n_oe_n    <= ~(next_state == `BAH_ST_STROBE ||
				next_state == `BAH_ST_END) || in_hard_reset;
		end
	end

	// slave response to the host
	always @(posedge aclk) begin
		if (!aresetn || in_hard_reset) begin
			slave_active     <= 1'b0;
			slave_ack        <= 1'b0;
			slave_read       <= 1'b0;
			slave_write_data <= 16'h0000;
			data_out         <= 32'h0000_0000;
		end else if (!slave_active) begin
			slave_ack <= 1'b0;
			if (!pin_sync[`BAH_SYN_SELECT] && bus_mode_select &&
					!owns_bus) begin
				slave_active <= 1'b1;
				slave_read   <= pin_sync[`BAH_SYN_DIR];
				data_out     <= {16'h0000, slave_read_data};
				if (!pin_sync[`BAH_SYN_DIR])
					slave_write_data <= pin_sync[`BAH_SYN_DATA_LO +: 16];
			end
		end else begin
			slave_ack <= 1'b1;
			if (pin_sync[`BAH_SYN_SELECT]) begin
				slave_active <= 1'b0;
				slave_ack    <= 1'b0;
			end
		end
	end

	assign slave_hit            = slave_ack & bus_mode_select;
	assign size_ack_low_n_out   = 1'b0;
	assign size_ack_high_n_out  = 1'b0;
	assign size_ack_low_n_oe_n  = ~slave_hit;
	assign size_ack_high_n_oe_n = ~slave_hit;
	// upper lanes driven too, always as zero
	assign data_oe_n            = ~(slave_active & slave_read);

	// user pins: inputs in hard reset, outputs while mastering
	always @(posedge aclk) begin
		if (!aresetn) begin
			user_pin_zero_out  <= 1'b0;
			user_pin_zero_oe_n <= 1'b1;
			user_pin_one_out   <= 1'b0;
			user_pin_one_oe_n  <= 1'b1;
		end else if (in_hard_reset) begin
			user_pin_zero_oe_n <= 1'b1;
			user_pin_one_oe_n  <= 1'b1;
		end else if (owns_bus || hold_acknowledge) begin
			user_pin_zero_out  <= data_config_register[`BAH_CFG_USER_OUT0];
			user_pin_one_out   <= data_config_register[`BAH_CFG_USER_OUT1];
			user_pin_zero_oe_n <= 1'b0;
			user_pin_one_oe_n  <= 1'b0;
		end else begin
			user_pin_zero_oe_n <= 1'b1;
			user_pin_one_oe_n  <= 1'b1;
		end
	end

	// register bus write side
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
	assign done_set      = (state == `BAH_ST_END);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 5'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `BAH_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == `BAH_OFS_CONFIG || aw_addr == `BAH_OFS_CONTROL ||
						aw_addr == `BAH_OFS_STATUS || aw_addr == `BAH_OFS_SLAVE_RD)
					s_axi_bresp <= `BAH_RESP_OKAY;
				else
					s_axi_bresp <= `BAH_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// registers steered by software, plus the strap capture
	always @(posedge aclk) begin
		if (!aresetn) begin
			data_config_register <= `BAH_CFG_RESET;
			slave_read_data      <= 16'h0000;
			start_req            <= 1'b0;
			done_flag            <= 1'b0;
		end else begin
			// only writable fields move; strap bits 8 and 9 stay read-only
			if (wr_fire && aw_addr == `BAH_OFS_CONFIG && w_strb[1])
				data_config_register[`BAH_CFG_USER_OUT1:`BAH_CFG_SYNC]
					<= w_data[`BAH_CFG_USER_OUT1:`BAH_CFG_SYNC];
			if (wr_fire && aw_addr == `BAH_OFS_CONFIG && w_strb[0])
				data_config_register[`BAH_CFG_WIDTH32] <=
					w_data[`BAH_CFG_WIDTH32];
			// last sample before release is what stays latched
			if (in_hard_reset) begin
				data_config_register[`BAH_CFG_USER_IN0] <=
					pin_sync[`BAH_SYN_USER0];
				data_config_register[`BAH_CFG_USER_IN1] <=
					pin_sync[`BAH_SYN_USER1];
			end
			if (wr_fire && aw_addr == `BAH_OFS_SLAVE_RD) begin
				if (w_strb[0])
					slave_read_data[7:0] <= w_data[7:0];
				if (w_strb[1])
					slave_read_data[15:8] <= w_data[15:8];
			end
			if (wr_fire && aw_addr == `BAH_OFS_CONTROL && w_strb[0] &&
					w_data[`BAH_CTL_START])
				start_req <= 1'b1;
			else if (state != `BAH_ST_IDLE || in_hard_reset)
				start_req <= 1'b0;
			// a completing cycle beats a simultaneous clear
			if (done_set)
				done_flag <= 1'b1;
			else if (wr_fire && aw_addr == `BAH_OFS_STATUS && w_strb[0] &&
					w_data[`BAH_STS_DONE])
				done_flag <= 1'b0;
		end
	end

	// register bus read side
	assign s_axi_arready = ~s_axi_rvalid;
	assign status_word = {26'h0, slave_active, owns_bus, state,
		done_flag};

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `BAH_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `BAH_RESP_OKAY;
			if (s_axi_araddr == `BAH_OFS_CONFIG)
				s_axi_rdata <= data_config_register;
			else if (s_axi_araddr == `BAH_OFS_CONTROL)
				s_axi_rdata <= {31'h0, start_req};
			else if (s_axi_araddr == `BAH_OFS_STATUS)
				s_axi_rdata <= status_word;
			else if (s_axi_araddr == `BAH_OFS_SLAVE_RD)
				s_axi_rdata <= {16'h0000, slave_read_data};
			else if (s_axi_araddr == `BAH_OFS_SLAVE_WR)
				s_axi_rdata <= {16'h0000, slave_write_data};
			else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `BAH_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // bah_handshake
